// ==== src/intc_params.svh ====
// Summary of operation
// RULE1 - Status bit shows an enabled pending source held back by core priority.
// RULE2 - Vector-hold set shows highest pending vector; clear shows last acknowledged.
// RULE3 - Four-bit new core level field equals the level itself, 0 to 15.
// RULE4 - Seven-bit vector field in bits 6..0; real vector is field plus 8.
// RULE5 - Status bits 14, 12 and 7 always read zero.
// RULE6 - Every source priority field resets to level 4.
// RULE7 - Equal nonzero priority on all sources is legal: single-level operation.
// RULE8 - Nesting-disable bit 15 of control register one stops interrupt nesting.
// RULE9 - Software clears a flag before it sets that source's enable.
// RULE10 - Service routine clears its flag or the request returns at once.
// RULE11 - Return from interrupt restores PC, status byte and previous core level.
// RULE12 - Trap handler clears its trap flag or the trap re-enters.
// RULE13 - ORing 0Eh into status low byte raises core to 7, masking users.
// RULE14 - Only user levels up to 7 are maskable; traps 8 to 15 never.
// RULE15 - Timed disable blocks levels 1 to 6 for a period; level 7 passes.
// RULE16 - Priority field 000 disables a source; 7 is the top user level.
// RULE17 - Request only for flag, enable and priority above the core level.
// RULE18 - Among qualifying requests the highest priority is chosen.
`ifndef INTC_PARAMS_SVH
`define INTC_PARAMS_SVH

// Register indices on the plain register port
`define IC_ADDR_FLAG 4'h0
`define IC_ADDR_ENABLE 4'h1
`define IC_ADDR_PRIO0 4'h2
`define IC_ADDR_PRIO3 4'h5
`define IC_ADDR_CTRL_ONE 4'h6
`define IC_ADDR_STATUS_LOW 4'h7
`define IC_ADDR_CTRL_STATUS 4'h8
`define IC_ADDR_TIMED_DIS 4'h9

// Field positions
`define IC_NEST_DIS_BIT 15
`define IC_REQ_UNACK_BIT 15
`define IC_VEC_HOLD_BIT 13
`define IC_LVL_LSB 1

// Reset values and fixed levels
`define IC_PRIO_RESET 3'h4
`define IC_PRIO_OFF 3'h0
`define IC_PRIO_TOP 3'h7
`define IC_LVL_MASK_ALL 4'h7
`define IC_LVL_RESET 4'h0
`define IC_TRAP_VEC_BASE 7'h70
`define IC_WORD_ZERO 16'h0000

`endif

// ==== src/intc_pkg.sv ====
package intc_pkg;

	// Result of a priority search
	typedef struct packed {
		logic found;
		logic [3:0] idx;
		logic [3:0] lvl;
	} pick_type;

endpackage

// ==== src/intc_stack_if.sv ====
`timescale 1ns/1ns
`default_nettype none

interface intc_stack_if #(
	parameter int AW = 4,
	parameter int DW = 4
);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;

	modport ctrl (
		output wr_en,
		output wr_addr,
		output wr_data,
		output rd_addr,
		input rd_data
	);

	modport mem (
		input wr_en,
		input wr_addr,
		input wr_data,
		input rd_addr,
		output rd_data
	);
endinterface

`default_nettype wire

// ==== src/intc_level_stack.sv ====
`timescale 1ns/1ns
`default_nettype none

module intc_level_stack #(
	parameter int DEPTH = 16,
	parameter int AW = 4,
	parameter int DW = 4
) (
	input wire logic clk,
	intc_stack_if.mem port
);
	logic [DW-1:0] mem_r [DEPTH];
	logic [DW-1:0] rd_data_r;

	// Saved levels need no reset: the pointer decides what is valid
	always_ff @(posedge clk)
	begin
		if (port.wr_en)
			mem_r[port.wr_addr] <= port.wr_data;
		rd_data_r <= mem_r[port.rd_addr];
	end

	assign port.rd_data = rd_data_r;
endmodule

`default_nettype wire

// ==== src/intc_top.sv ====
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "intc_params.svh"

module intc_top #(
	parameter int N_SRC = 16,
	parameter int N_TRAP = 8,
	parameter int STACK_DEPTH = 16,
	parameter int STACK_AW = 4,
	parameter int DIS_W = 16
) (
	input wire logic I_REF_CLK,
	input wire logic I_RESET,
	input wire logic [3:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [15:0] O_RDATA,
	input wire logic [N_SRC-1:0] I_SRC_EVENT,
	input wire logic [N_TRAP-1:0] I_TRAP_EVENT,
	output logic O_IRQ,
	output logic [3:0] O_IRQ_LEVEL,
	output logic [6:0] O_IRQ_VECTOR,
	input wire logic I_ACK,
	input wire logic I_RETURN,
	output logic [3:0] O_CORE_LEVEL
);
	// Software-visible state
	// Trap flags share control register one with the nesting bit
	logic [N_SRC-1:0] flag_r;
	logic [N_SRC-1:0] enable_r;
	logic [2:0] prio_r [N_SRC];
	logic nest_dis_r;
	logic [N_TRAP-1:0] trap_r;
	logic [3:0] core_lvl_r;
	logic vec_hold_r;
	logic [DIS_W-1:0] dis_cnt_r;
	// Request presented to the core
	logic irq_r;
	logic [3:0] irq_lvl_r;
	logic [6:0] irq_vec_r;
	logic [6:0] last_vec_r;
	logic [STACK_AW:0] sp_r;
	logic [15:0] rdata_r;

	// Saved core levels, one slot per acknowledge
	intc_stack_if #(.AW(STACK_AW), .DW(4)) stk ();

	intc_level_stack #(
		.DEPTH(STACK_DEPTH),
		.AW(STACK_AW),
		.DW(4)
	) u_stack (
		.clk(I_REF_CLK),
		.port(stk.mem)
	);

	// Highest level among the masked candidates; ties go to the lowest index
	// Walking downward lets an equal level found later win, which favours low indices
	function automatic intc_pkg::pick_type pick_user(
		input logic [N_SRC-1:0] cand,
		input logic [3*N_SRC-1:0] prios
	);
		intc_pkg::pick_type p;
		logic [2:0] pr;
		p = '0;
		for (int i = N_SRC - 1; i >= 0; i--)
		begin
			pr = prios[3*i +: 3];
			if (cand[i] && ({1'b0, pr} >= p.lvl || !p.found))
			begin
				p.found = 1'b1;
				p.idx = 4'(i);
				p.lvl = {1'b0, pr};
			end
		end
		return p;
	endfunction

	// Highest trap; trap t sits at level 8 + t
	// Walking upward leaves the highest trap in place
	function automatic intc_pkg::pick_type pick_trap(input logic [N_TRAP-1:0] cand);
		intc_pkg::pick_type p;
		p = '0;
		for (int t = 0; t < N_TRAP; t++)
		begin
			if (cand[t])
			begin
				p.found = 1'b1;
				p.idx = 4'(t);
				p.lvl = 4'(8 + t);
			end
		end
		return p;
	endfunction

	// Flattened priorities and per-source qualification
	// Timed disable spares level 7, and traps never see it
	logic [3*N_SRC-1:0] prio_flat;
	logic [N_SRC-1:0] pending;
	logic [N_SRC-1:0] qualify;
	logic [N_TRAP-1:0] trap_ok;
	wire dis_busy = (dis_cnt_r != '0);

	always_comb
	begin
		for (int i = 0; i < N_SRC; i++)
		begin
			prio_flat[3*i +: 3] = prio_r[i];
			pending[i] = flag_r[i] && enable_r[i] && (prio_r[i] != `IC_PRIO_OFF); // see RULE16
			qualify[i] = pending[i] && ({1'b0, prio_r[i]} > core_lvl_r) // see RULE17
				&& !(dis_busy && prio_r[i] != `IC_PRIO_TOP); // see RULE15
		end
		for (int t = 0; t < N_TRAP; t++)
			trap_ok[t] = trap_r[t] && (4'(8 + t) > core_lvl_r); // see RULE14
	end

	// Winner selection: traps outrank every user level
	// Pending picks ignore the core level; they only feed the status vector field
	wire intc_pkg::pick_type user_win = pick_user(qualify, prio_flat); // see RULE18
	wire intc_pkg::pick_type trap_win = pick_trap(trap_ok);
	wire intc_pkg::pick_type user_pend = pick_user(pending, prio_flat);
	wire intc_pkg::pick_type trap_pend = pick_trap(trap_r);
	wire req_found = trap_win.found || user_win.found;
	wire [3:0] req_lvl = trap_win.found ? trap_win.lvl : user_win.lvl;
	wire [6:0] req_vec = trap_win.found ? (`IC_TRAP_VEC_BASE | 7'(trap_win.idx))
		: 7'(user_win.idx);
	wire [6:0] pend_vec = trap_pend.found ? (`IC_TRAP_VEC_BASE | 7'(trap_pend.idx))
		: 7'(user_pend.idx);

	// Held-back request: enabled and pending, but core level too high or timed disable active
	wire req_unack = |(pending & ~qualify); // see RULE1

	// Core handshake decode
	wire ack_take = I_ACK && irq_r;
	wire ret_take = I_RETURN && !ack_take && (sp_r != '0);
	// A full stack drops the push; the write is gated too or slot 0 would be lost
	wire stack_full = (sp_r == (STACK_AW+1)'(STACK_DEPTH));
	wire [3:0] ack_lvl = (nest_dis_r && irq_lvl_r <= `IC_LVL_MASK_ALL) ? `IC_LVL_MASK_ALL
		: irq_lvl_r; // see RULE8

	// Push the level being left; the read port always looks one slot below the pointer,
	// so a return needs two cycles after the last push to see fresh data
	assign stk.wr_en = ack_take && !stack_full;
	assign stk.wr_addr = sp_r[STACK_AW-1:0];
	assign stk.wr_data = core_lvl_r;
	assign stk.rd_addr = STACK_AW'(sp_r - 1'b1);

	// Priority words sit in one contiguous block of indices
	function automatic logic is_prio_addr(input logic [3:0] a);
		return a >= `IC_ADDR_PRIO0 && a <= `IC_ADDR_PRIO3;
	endfunction

	// Register write decode; one strobe touches one register
	wire wr_flag = I_WR && I_ADDR == `IC_ADDR_FLAG;
	wire wr_en = I_WR && I_ADDR == `IC_ADDR_ENABLE;
	wire wr_ctrl1 = I_WR && I_ADDR == `IC_ADDR_CTRL_ONE;
	wire wr_slow = I_WR && I_ADDR == `IC_ADDR_STATUS_LOW;
	wire wr_cstat = I_WR && I_ADDR == `IC_ADDR_CTRL_STATUS;
	wire wr_dis = I_WR && I_ADDR == `IC_ADDR_TIMED_DIS;
	wire wr_prio = I_WR && is_prio_addr(I_ADDR);
	wire [1:0] prio_grp = 2'(I_ADDR - `IC_ADDR_PRIO0);

	// Status word; unused positions stay zero
	wire [6:0] vec_field = vec_hold_r ? pend_vec : last_vec_r; // see RULE2
	wire [15:0] cstat_word = {req_unack, 1'b0, vec_hold_r, 1'b0, // see RULE5
		irq_lvl_r, 1'b0, vec_field}; // see RULE3 see RULE4

	// Priority register readback, four sources to a word
	// Bit 3 of each nibble has no storage and reads zero
	logic [15:0] prio_word;
	always_comb
	begin
		prio_word = `IC_WORD_ZERO;
		for (int k = 0; k < 4; k++)
			prio_word[4*k +: 3] = prio_r[4*prio_grp + k];
	end

	// Read selection; an unmapped index reads zero
	// Reads have no side effects: software clears flags by writing
	logic [15:0] rd_word;
	always_comb
	begin
		unique case (I_ADDR)
			`IC_ADDR_FLAG: rd_word = 16'(flag_r);
			`IC_ADDR_ENABLE: rd_word = 16'(enable_r);
			`IC_ADDR_CTRL_ONE: rd_word = {nest_dis_r, 7'h00, 8'(trap_r)};
			`IC_ADDR_STATUS_LOW: rd_word = {12'h000, core_lvl_r[2:0], core_lvl_r[3]};
			`IC_ADDR_CTRL_STATUS: rd_word = cstat_word;
			`IC_ADDR_TIMED_DIS: rd_word = 16'(dis_cnt_r);
			default: rd_word = is_prio_addr(I_ADDR) ? prio_word : `IC_WORD_ZERO;
		endcase
	end

	// Flags: a hardware event wins over a software clear in the same cycle
	// Software writes whole words; keeping other flags is its read-modify-write
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			flag_r <= '0;
			trap_r <= '0;
		end
		else
		begin
			flag_r <= (wr_flag ? I_WDATA[N_SRC-1:0] : flag_r) | I_SRC_EVENT; // see RULE10
			trap_r <= (wr_ctrl1 ? I_WDATA[N_TRAP-1:0] : trap_r) | I_TRAP_EVENT; // see RULE12
		end
	end

	// Configuration registers
	// Priority writes carry four three-bit fields, one per nibble
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			enable_r <= '0;
			nest_dis_r <= 1'b0;
			vec_hold_r <= 1'b0;
			for (int i = 0; i < N_SRC; i++)
				prio_r[i] <= `IC_PRIO_RESET; // see RULE6
		end
		else
		begin
			if (wr_en)
				enable_r <= I_WDATA[N_SRC-1:0]; // see RULE9
			if (wr_ctrl1)
				nest_dis_r <= I_WDATA[`IC_NEST_DIS_BIT];
			if (wr_cstat)
				vec_hold_r <= I_WDATA[`IC_VEC_HOLD_BIT];
			for (int k = 0; k < 4; k++)
				if (wr_prio)
					prio_r[4*prio_grp + k] <= I_WDATA[4*k +: 3]; // see RULE7
		end
	end

	// Timed disable counts down one per clock
	// A new write restarts the window; writing zero ends it at once
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
			dis_cnt_r <= '0;
		else if (wr_dis)
			dis_cnt_r <= DIS_W'(I_WDATA); // see RULE15
		else if (dis_busy)
			dis_cnt_r <= dis_cnt_r - 1'b1;
	end

	// Core level: acknowledge beats return, return beats a software write
	// Nesting disable lifts a user acknowledge to 7; traps keep their own level
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			core_lvl_r <= `IC_LVL_RESET;
			sp_r <= '0;
		end
		else if (ack_take)
		begin
			core_lvl_r <= ack_lvl;
			if (!stack_full)
				sp_r <= sp_r + 1'b1;
		end
		else if (ret_take)
		begin
			core_lvl_r <= stk.rd_data; // see RULE11
			sp_r <= sp_r - 1'b1;
		end
		else if (wr_slow)
			core_lvl_r[2:0] <= I_WDATA[`IC_LVL_LSB +: 3]; // see RULE13
	end

	// Request goes quiet for the cycle after an acknowledge so it is re-evaluated
	// With no request the level output shows the core level, as the status field wants
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			irq_r <= 1'b0;
			irq_lvl_r <= `IC_LVL_RESET;
			irq_vec_r <= '0;
			last_vec_r <= '0;
			rdata_r <= `IC_WORD_ZERO;
		end
		else
		begin
			irq_r <= req_found && !ack_take; // see RULE17
			irq_lvl_r <= req_found ? req_lvl : core_lvl_r;
			irq_vec_r <= req_vec;
			if (ack_take)
				last_vec_r <= irq_vec_r;
			rdata_r <= I_RD ? rd_word : `IC_WORD_ZERO;
		end
	end

	// Every output comes straight from a flip-flop
	assign O_RDATA = rdata_r;
	assign O_IRQ = irq_r;
	assign O_IRQ_LEVEL = irq_lvl_r;
	assign O_IRQ_VECTOR = irq_vec_r;
	assign O_CORE_LEVEL = core_lvl_r;
endmodule

`default_nettype wire

// ==== verif/intc_core_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module intc_core_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_irq,
	input wire logic i_ack_on,
	input wire logic [3:0] i_slow,
	output logic o_ack
);
	logic [3:0] wait_r;

	// Core takes a standing request only after its service delay, one pulse each
	always_ff @(posedge i_clk)
	begin
		if (i_rst || o_ack || !i_irq)
		begin
			wait_r <= 4'h0;
			o_ack <= 1'b0;
		end
		else if (i_ack_on && wait_r == i_slow)
			o_ack <= 1'b1;
		else
			wait_r <= wait_r + 4'h1;
	end
endmodule

`default_nettype wire

// ==== verif/intc_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "intc_params.svh"

module intc_monitor (
	input wire logic I_REF_CLK,
	input wire logic I_RESET,
	input wire logic [3:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [15:0] O_RDATA,
	input wire logic O_IRQ,
	input wire logic [3:0] O_IRQ_LEVEL,
	input wire logic [6:0] O_IRQ_VECTOR,
	input wire logic I_ACK,
	input wire logic I_RETURN,
	input wire logic [3:0] O_CORE_LEVEL
);
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (I_RESET);

	// An acknowledge counts only against a standing request
	sequence s_ack; I_ACK && O_IRQ; endsequence
	sequence s_stat; I_RD && I_ADDR == `IC_ADDR_CTRL_STATUS; endsequence

	property p_drop; s_ack |=> !O_IRQ; endproperty
	a_drop: assert property (p_drop) else $error("request stood after ack");
	property p_above; O_IRQ && $stable(O_CORE_LEVEL) |-> O_IRQ_LEVEL > O_CORE_LEVEL; endproperty
	a_above: assert property (p_above) else $error("request not above core");
	property p_trap; O_IRQ && O_IRQ_VECTOR[6:3] == 4'he
		|-> O_IRQ_LEVEL == {1'b1, O_IRQ_VECTOR[2:0]}; endproperty
	a_trap: assert property (p_trap) else $error("trap level wrong");
	property p_unimpl; s_stat |=> !O_RDATA[14] && !O_RDATA[12] && !O_RDATA[7]; endproperty
	a_unimpl: assert property (p_unimpl) else $error("unused status bit set");
	property p_lvl; s_stat |=> O_RDATA[11:8] == $past(O_IRQ_LEVEL); endproperty
	a_lvl: assert property (p_lvl) else $error("level field wrong");
	property p_cause; $changed(O_CORE_LEVEL)
		|-> $past(I_ACK) || $past(I_RETURN) || $past(I_WR); endproperty
	a_cause: assert property (p_cause) else $error("core level moved alone");
	property p_ack_lvl; s_ack
		|=> O_CORE_LEVEL >= $past(O_IRQ_LEVEL) && O_CORE_LEVEL != 4'h0; endproperty
	a_ack_lvl: assert property (p_ack_lvl) else $error("core level after ack");
	property p_mask; I_WR && I_ADDR == `IC_ADDR_STATUS_LOW && I_WDATA[3:1] == 3'h7 && !I_ACK
		&& !I_RETURN |=> O_CORE_LEVEL[2:0] == 3'h7; endproperty
	a_mask: assert property (p_mask) else $error("mask write ignored");

	// Nesting-disable setting as software last wrote it
	logic nest_seen_r;
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
			nest_seen_r <= 1'b0;
		else if (I_WR && I_ADDR == `IC_ADDR_CTRL_ONE)
			nest_seen_r <= I_WDATA[`IC_NEST_DIS_BIT];
	end

	// With nesting off, any acknowledged user request lifts the core to 7
	property p_nest; s_ack && nest_seen_r && O_IRQ_LEVEL <= 4'h7
		|=> O_CORE_LEVEL == 4'h7; endproperty
	a_nest: assert property (p_nest) else $error("nesting not held off");
endmodule

bind intc_top intc_monitor u_mon (.I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ),
	.O_IRQ_LEVEL(O_IRQ_LEVEL), .O_IRQ_VECTOR(O_IRQ_VECTOR), .I_ACK(I_ACK),
	.I_RETURN(I_RETURN), .O_CORE_LEVEL(O_CORE_LEVEL));

`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "intc_params.svh"

module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] src = 16'h0000;
	logic [7:0] trap = 8'h00;
	logic ret = 1'b0;
	logic ack_on = 1'b0;
	logic ack, irq;
	logic [15:0] rdata, rv;
	logic [3:0] lvl, core;
	logic [6:0] vec;
	int bad_count = 0;
	int comparisons = 0;

	// Reference clock
	always #5 clk = ~clk;

	intc_top DUT (.I_REF_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
		.I_RD(rd), .O_RDATA(rdata), .I_SRC_EVENT(src), .I_TRAP_EVENT(trap), .O_IRQ(irq),
		.O_IRQ_LEVEL(lvl), .O_IRQ_VECTOR(vec), .I_ACK(ack), .I_RETURN(ret), .O_CORE_LEVEL(core));
	intc_core_model core_side (.i_clk(clk), .i_rst(rst), .i_irq(irq), .i_ack_on(ack_on),
		.i_slow(4'h3), .o_ack(ack));

	task chk(input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e)
		begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task finish_test;
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// One-cycle strobes; read data is taken in the only cycle it stands
	task wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task rreg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		rv = rdata;
	endtask

	task pulse(input logic [15:0] s, input logic [7:0] t);
		@(posedge clk);
		src <= s;
		trap <= t;
		@(posedge clk);
		src <= 16'h0000;
		trap <= 8'h00;
	endtask

	// Return strobe for one cycle; the level is back in the cycle after it
	task ret_pulse;
		@(posedge clk);
		ret <= 1'b1;
		@(posedge clk);
		ret <= 1'b0;
	endtask

	// Bounded wait for the request line, then judge it
	task wirq(input logic v);
		#1;
		repeat (30)
			if (irq !== v)
				@(posedge clk) #1;
		chk({15'h0, irq}, {15'h0, v});
	endtask

	task t_reset;
		for (logic [3:0] a = 4'h2; a < 4'h6; a++)
		begin
			rreg(a);
			chk(rv, 16'h4444);
		end
		rreg(`IC_ADDR_CTRL_STATUS);
		chk(rv, 16'h0000);
		rreg(4'hA);
		chk(rv, 16'h0000);
	endtask

	task t_one;
		wreg(`IC_ADDR_FLAG, 16'h0000);
		wreg(`IC_ADDR_ENABLE, 16'h0008);
		pulse(16'h0008, 8'h00);
		wirq(1'b1);
		chk({lvl, 5'h0, vec}, 16'h4003);
		ack_on = 1'b1;
		wirq(1'b0);
		ack_on = 1'b0;
		chk({12'h0, core}, 16'h0004);
		rreg(`IC_ADDR_CTRL_STATUS);
		chk(rv, 16'h8403);
		ret_pulse;
		wirq(1'b1);
		chk({12'h0, core}, 16'h0000);
		wreg(`IC_ADDR_FLAG, 16'h0000);
		wirq(1'b0);
	endtask

	task t_prio;
		wreg(`IC_ADDR_PRIO0, 16'h0264);
		wreg(`IC_ADDR_ENABLE, 16'h000E);
		pulse(16'h000E, 8'h00);
		wirq(1'b1);
		chk({lvl, 5'h0, vec}, 16'h6001);
		wreg(`IC_ADDR_PRIO0, 16'h0334);
		repeat (3) @(posedge clk);
		wirq(1'b1);
		chk({lvl, 5'h0, vec}, 16'h3001);
		wreg(`IC_ADDR_PRIO0, 16'h0004);
		repeat (3) @(posedge clk);
		wirq(1'b0);
		wreg(`IC_ADDR_FLAG, 16'h0000);
	endtask

	task t_mask;
		wreg(`IC_ADDR_TIMED_DIS, 16'h0064);
		wreg(`IC_ADDR_PRIO0, 16'h0570);
		pulse(16'h0004, 8'h00);
		repeat (6) @(posedge clk);
		wirq(1'b0);
		pulse(16'h0002, 8'h00);
		wirq(1'b1);
		chk({lvl, 5'h0, vec}, 16'h7001);
		wreg(`IC_ADDR_STATUS_LOW, 16'h000E);
		wirq(1'b0);
		chk({12'h0, core}, 16'h0007);
		pulse(16'h0000, 8'h01);
		wirq(1'b1);
		chk({lvl, 5'h0, vec}, 16'h8070);
		wreg(`IC_ADDR_CTRL_ONE, 16'h0000);
		wirq(1'b0);
		wreg(`IC_ADDR_CTRL_STATUS, 16'h2000);
		rreg(`IC_ADDR_CTRL_STATUS);
		chk(rv & 16'hA07F, 16'hA001);
	endtask

	// Nesting off: a level 5 acknowledge lifts the core to 7, a trap still nests
	task t_nest;
		wreg(`IC_ADDR_TIMED_DIS, 16'h0000);
		wreg(`IC_ADDR_FLAG, 16'h0004);
		wreg(`IC_ADDR_CTRL_ONE, 16'h8000);
		wreg(`IC_ADDR_STATUS_LOW, 16'h0000);
		wirq(1'b1);
		chk({lvl, 5'h0, vec}, 16'h5002);
		ack_on = 1'b1;
		wirq(1'b0);
		ack_on = 1'b0;
		chk({12'h0, core}, 16'h0007);
		pulse(16'h0000, 8'h04);
		wirq(1'b1);
		chk({lvl, 5'h0, vec}, 16'hA072);
		ack_on = 1'b1;
		wirq(1'b0);
		ack_on = 1'b0;
		chk({12'h0, core}, 16'h000A);
		wreg(`IC_ADDR_CTRL_ONE, 16'h8000);
		ret_pulse;
		#1;
		chk({12'h0, core}, 16'h0007);
		wirq(1'b0);
	endtask

	// Main sequence after five reset cycles
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_one;
		t_prio;
		t_mask;
		t_nest;
		finish_test;
	end

	// Whole run needs well under a thousand cycles
	initial
	begin
		#50000;
		bad_count++;
		finish_test;
	end
endmodule

`default_nettype wire
